// [common/pvm_regs.svh]
// Summary of operation
// - entry pins must stay still 100 ns after high voltage, else no entry
// - loaded command and address are kept across successive operations
// - address high byte is kept until the programmer reloads it
// - chip erase clears flash, eeprom, then lock bits; fuses stay untouched
// - keep-eeprom fuse programmed means chip erase leaves eeprom intact
// - command 1000 0000 plus write pulse erases; busy until done, commands refused
// - load strobe action: 10 command, 00 address byte, 01 data byte
// - address load with first byte-select low stores address low byte
// - address load with first byte-select high stores address high byte
// - flash data load: first byte-select picks low or high data byte
// - page latch pulse with first byte-select high stores word into page buffer
// - command 0001 0000 selects flash page writing
// - write pulse with first byte-select low programs flash page, busy meanwhile
// - upper bits of address low byte form part of the page address
// - command 0000 0000 is no operation and clears the write arming
// - command 0001 0001 writes eeprom pages the same way, busy meanwhile
// - command 0000 0010 reads flash low or high byte by first byte-select
// - command 0000 0011 reads eeprom byte with first byte-select low
// - command 0100 0000 writes low or high fuse byte from data low byte
// - done flag reads 0 while busy and 1 when ready
// - data bus is driven only while output enable is low
`ifndef PVM_REGS_SVH
`define PVM_REGS_SVH

`define PVM_CLK_MHZ 25
`define PVM_ENTRY_HOLD_NS 100
`define PVM_ENTRY_HOLD_CYC ((`PVM_ENTRY_HOLD_NS * `PVM_CLK_MHZ + 999) / 1000)
`define PVM_PROG_US 3700
`define PVM_PROG_CYC (`PVM_PROG_US * `PVM_CLK_MHZ)
`define PVM_ERASE_US 7500
`define PVM_ERASE_CYC (`PVM_ERASE_US * `PVM_CLK_MHZ)

`define PVM_CMD_NOP 8'h00
`define PVM_CMD_ERASE 8'h80
`define PVM_CMD_FUSE_WR 8'h40
`define PVM_CMD_FLASH_WR 8'h10
`define PVM_CMD_EE_WR 8'h11
`define PVM_CMD_FLASH_RD 8'h02
`define PVM_CMD_EE_RD 8'h03

`define PVM_FUSE_LOW_RST 8'hE1
`define PVM_FUSE_HIGH_RST 8'hFF
`define PVM_LOCK_RST 8'hFF
`define PVM_ERASED_BYTE 8'hFF

`endif

// [common/pvm_pkg.sv]
package pvm_pkg;

  typedef enum logic [1:0]
  {
    PVM_ACT_ADDR = 2'b00,
    PVM_ACT_DATA = 2'b01,
    PVM_ACT_CMD = 2'b10,
    PVM_ACT_IDLE = 2'b11
  } pvm_action_t;

  typedef enum logic [1:0]
  {
    PVM_ST_IDLE = 2'b00,
    PVM_ST_BUSY = 2'b01,
    PVM_ST_COMMIT = 2'b11,
    PVM_ST_LOCK = 2'b10
  } pvm_state_t;

  typedef enum logic [1:0]
  {
    PVM_EN_OFF = 2'b00,
    PVM_EN_SETTLE = 2'b01,
    PVM_EN_ACTIVE = 2'b11,
    PVM_EN_FAILED = 2'b10
  } pvm_entry_t;

  typedef enum logic [1:0]
  {
    PVM_OP_ERASE = 2'b00,
    PVM_OP_FLASH = 2'b01,
    PVM_OP_EE = 2'b10,
    PVM_OP_FUSE = 2'b11
  } pvm_op_t;

endpackage : pvm_pkg

// [hw/pvm_entry_guard.sv]
`timescale 1ns/1ns
`include "pvm_regs.svh"

module pvm_entry_guard #(
  parameter int HOLD_CYC = `PVM_ENTRY_HOLD_CYC
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic high_voltage,
  input wire logic [3:0] entry_pins,
  output logic mode_active
);
  import pvm_pkg::*;

  initial
  begin
    if (HOLD_CYC < 1 || HOLD_CYC > 255)
      $error("pvm_entry_guard: HOLD_CYC out of range");
  end

  typedef struct packed {
    pvm_entry_t st;
    logic [7:0] cnt;
    logic prev_hv;
    logic active;
  } guard_t;

  guard_t s;
  guard_t next_s;

  always_comb
  begin
    next_s = s;
    next_s.prev_hv = high_voltage;
    case (s.st)
      PVM_EN_OFF:
      begin
        // pins must already read 0000 when the high voltage arrives
        if (high_voltage && !s.prev_hv)
        begin
          next_s.st = (entry_pins == 4'h0) ? PVM_EN_SETTLE : PVM_EN_FAILED;
          next_s.cnt = 8'h00;
        end
      end
      PVM_EN_SETTLE:
      begin
        if (!high_voltage)
          next_s.st = PVM_EN_OFF;
        else if (entry_pins != 4'h0)
          next_s.st = PVM_EN_FAILED;
        else if (s.cnt == 8'(HOLD_CYC - 1))
        begin
          next_s.st = PVM_EN_ACTIVE;
          next_s.active = 1'b1;
        end
        else
          next_s.cnt = s.cnt + 8'h01;
      end
      PVM_EN_ACTIVE:
      begin
        if (!high_voltage)
        begin
          next_s.st = PVM_EN_OFF;
          next_s.active = 1'b0;
        end
      end
      PVM_EN_FAILED:
      begin
        // stays locked out until the high voltage is removed
        if (!high_voltage)
          next_s.st = PVM_EN_OFF;
      end
      default:
      begin
        next_s.st = PVM_EN_OFF;
        next_s.active = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s.st <= PVM_EN_OFF;
      s.cnt <= 8'h00;
      s.prev_hv <= 1'b0;
      s.active <= 1'b0;
    end
    else
      s <= next_s;
  end

  assign mode_active = s.active;

endmodule : pvm_entry_guard

// [hw/pvm_port.sv]
`timescale 1ns/1ns
`include "pvm_regs.svh"

module pvm_port #(
  parameter int FLASH_AW = 15,
  parameter int FLASH_PAGE_W = 7,
  parameter int EE_AW = 11,
  parameter int EE_PAGE_W = 3,
  parameter int PROG_CYC = `PVM_PROG_CYC,
  parameter int ERASE_CYC = `PVM_ERASE_CYC,
  parameter int KEEP_EE_BIT = 3,
  parameter logic [7:0] FUSE_LOW_INIT = `PVM_FUSE_LOW_RST,
  parameter logic [7:0] FUSE_HIGH_INIT = `PVM_FUSE_HIGH_RST
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic high_voltage,
  input wire logic load_strobe,
  input wire logic strobe_action_msb,
  input wire logic strobe_action_lsb,
  input wire logic byte_select_first,
  input wire logic byte_select_second,
  input wire logic page_latch_pulse,
  input wire logic write_n,
  input wire logic output_enable_n,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic programming_done_flag,
  output logic [7:0] fuse_low,
  output logic [7:0] fuse_high,
  output logic [7:0] lock_bits,
  output pvm_pkg::pvm_state_t engine_state
);
  import pvm_pkg::*;

  localparam int FLASH_WORDS = 1 << FLASH_AW;
  localparam int EE_BYTES = 1 << EE_AW;
  localparam int FPAGE_WORDS = 1 << FLASH_PAGE_W;
  localparam int EPAGE_BYTES = 1 << EE_PAGE_W;

  initial
  begin
    if (FLASH_AW < 9 || FLASH_AW > 16 || EE_AW < 9 || EE_AW > 16)
      $error("pvm_port: address widths must lie in 9..16");
    if (FLASH_PAGE_W < 1 || FLASH_PAGE_W > 8 || EE_PAGE_W < 1 || EE_PAGE_W > 8)
      $error("pvm_port: page widths must lie in 1..8");
    if (PROG_CYC < 1 || ERASE_CYC < 1 || PROG_CYC >= (1 << 24) || ERASE_CYC >= (1 << 24))
      $error("pvm_port: busy counts must lie in 1..2^24-1");
    if (KEEP_EE_BIT < 0 || KEEP_EE_BIT > 7)
      $error("pvm_port: KEEP_EE_BIT must lie in 0..7");
  end

  typedef struct packed {
    pvm_state_t st;
    pvm_op_t op;
    logic [23:0] busy_cnt;
    logic [7:0] command;
    logic [7:0] addr_lo;
    logic [7:0] addr_hi;
    logic [7:0] data_lo;
    logic [7:0] data_hi;
    logic write_armed;
    logic fuse_sel_high;
    logic prev_strobe;
    logic prev_latch;
    logic prev_write_n;
    logic ready;
    logic [7:0] dout;
    logic doe;
    logic [7:0] fuse_low;
    logic [7:0] fuse_high;
    logic [7:0] lock;
    logic [FPAGE_WORDS-1:0][15:0] fbuf;
    logic [EPAGE_BYTES-1:0][7:0] ebuf;
    logic [FLASH_WORDS-1:0][15:0] flash;
    logic [EE_BYTES-1:0][7:0] eeprom;
  } port_state_t;

  port_state_t s;
  port_state_t next_s;
  logic mode_active;
  logic strobe_rise;
  logic latch_rise;
  logic write_fall;
  logic idle;
  logic [15:0] full_addr;
  logic [FLASH_AW-1:0] flash_addr;
  logic [EE_AW-1:0] ee_addr;
  logic [FLASH_AW-FLASH_PAGE_W-1:0] flash_page;
  logic [EE_AW-EE_PAGE_W-1:0] ee_page;
  logic [15:0] flash_word;
  logic [7:0] ee_byte;
  pvm_action_t action;

  pvm_entry_guard #(
    .HOLD_CYC(`PVM_ENTRY_HOLD_CYC)
  ) u_guard (
    .clk(clk),
    .rst(rst),
    .high_voltage(high_voltage),
    .entry_pins({page_latch_pulse, strobe_action_msb, strobe_action_lsb, byte_select_first}),
    .mode_active(mode_active)
  );

  // edges are found against last cycle's pin values, since pins are synchronous
  assign strobe_rise = mode_active && load_strobe && !s.prev_strobe;
  assign latch_rise = mode_active && page_latch_pulse && !s.prev_latch;
  assign write_fall = mode_active && !write_n && s.prev_write_n;
  assign idle = (s.st == PVM_ST_IDLE);
  assign action = pvm_action_t'({strobe_action_msb, strobe_action_lsb});

  // address registers persist, so only the changed byte needs reloading
  assign full_addr = {s.addr_hi, s.addr_lo};
  assign flash_addr = full_addr[FLASH_AW-1:0];
  assign ee_addr = full_addr[EE_AW-1:0];
  // page number takes the upper bits of the low byte as well
  assign flash_page = flash_addr[FLASH_AW-1:FLASH_PAGE_W];
  assign ee_page = ee_addr[EE_AW-1:EE_PAGE_W];
  assign flash_word = s.flash[flash_addr];
  assign ee_byte = s.eeprom[ee_addr];

  always_comb
  begin
    next_s = s;
    next_s.prev_strobe = load_strobe;
    next_s.prev_latch = page_latch_pulse;
    next_s.prev_write_n = write_n;

    // new commands and loads are ignored while an operation runs
    if (strobe_rise && idle)
    begin
      case (action)
        PVM_ACT_CMD:
        begin
          next_s.command = data_in;
          // any write command arms; nop and reads drop the arming
          next_s.write_armed = (data_in == `PVM_CMD_FLASH_WR)
            || (data_in == `PVM_CMD_EE_WR)
            || (data_in == `PVM_CMD_ERASE)
            || (data_in == `PVM_CMD_FUSE_WR);
        end
        PVM_ACT_ADDR:
        begin
          if (byte_select_first)
            next_s.addr_hi = data_in;
          else
            next_s.addr_lo = data_in;
        end
        PVM_ACT_DATA:
        begin
          if (byte_select_first)
            next_s.data_hi = data_in;
          else
            next_s.data_lo = data_in;
        end
        PVM_ACT_IDLE:
        begin
          next_s.command = s.command;
        end
        default:
        begin
          next_s.command = s.command;
        end
      endcase
    end

    // page buffer fill; word position is the low address bits
    if (latch_rise && idle)
    begin
      if (s.command == `PVM_CMD_FLASH_WR && byte_select_first)
        next_s.fbuf[s.addr_lo[FLASH_PAGE_W-1:0]] = {s.data_hi, s.data_lo};
      else if (s.command == `PVM_CMD_EE_WR)
        next_s.ebuf[s.addr_lo[EE_PAGE_W-1:0]] = s.data_lo;
    end

    case (s.st)
      PVM_ST_IDLE:
      begin
        if (write_fall && s.write_armed)
        begin
          next_s.busy_cnt = 24'(PROG_CYC - 1);
          if (s.command == `PVM_CMD_ERASE)
          begin
            next_s.op = PVM_OP_ERASE;
            next_s.busy_cnt = 24'(ERASE_CYC - 1);
            next_s.st = PVM_ST_BUSY;
            next_s.ready = 1'b0;
          end
          else if (s.command == `PVM_CMD_FLASH_WR && !byte_select_first)
          begin
            next_s.op = PVM_OP_FLASH;
            next_s.st = PVM_ST_BUSY;
            next_s.ready = 1'b0;
          end
          else if (s.command == `PVM_CMD_EE_WR && !byte_select_first)
          begin
            next_s.op = PVM_OP_EE;
            next_s.st = PVM_ST_BUSY;
            next_s.ready = 1'b0;
          end
          else if (s.command == `PVM_CMD_FUSE_WR && !byte_select_second)
          begin
            next_s.op = PVM_OP_FUSE;
            next_s.fuse_sel_high = byte_select_first;
            next_s.st = PVM_ST_BUSY;
            next_s.ready = 1'b0;
          end
        end
      end
      PVM_ST_BUSY:
      begin
        // the done flag stays low through the whole count
        if (s.busy_cnt == 24'h000000)
          next_s.st = PVM_ST_COMMIT;
        else
          next_s.busy_cnt = s.busy_cnt - 24'h000001;
      end
      PVM_ST_COMMIT:
      begin
        next_s.st = PVM_ST_IDLE;
        next_s.ready = 1'b1;
        case (s.op)
          PVM_OP_ERASE:
          begin
            // fuses are left alone; lock bits wait for the flash to be clear
            for (int i = 0; i < FLASH_WORDS; i++)
              next_s.flash[i] = {`PVM_ERASED_BYTE, `PVM_ERASED_BYTE};
            // keep-eeprom fuse is read live, so a fresh program takes effect
            if (s.fuse_high[KEEP_EE_BIT])
            begin
              for (int j = 0; j < EE_BYTES; j++)
                next_s.eeprom[j] = `PVM_ERASED_BYTE;
            end
            next_s.st = PVM_ST_LOCK;
            next_s.ready = 1'b0;
          end
          PVM_OP_FLASH:
          begin
            for (int k = 0; k < FPAGE_WORDS; k++)
              next_s.flash[{flash_page, FLASH_PAGE_W'(k)}] = s.fbuf[k];
          end
          PVM_OP_EE:
          begin
            for (int m = 0; m < EPAGE_BYTES; m++)
              next_s.eeprom[{ee_page, EE_PAGE_W'(m)}] = s.ebuf[m];
          end
          PVM_OP_FUSE:
          begin
            // bit 0 programs, bit 1 erases: the byte is stored as given
            if (s.fuse_sel_high)
              next_s.fuse_high = s.data_lo;
            else
              next_s.fuse_low = s.data_lo;
          end
          default:
          begin
            next_s.st = PVM_ST_IDLE;
          end
        endcase
      end
      PVM_ST_LOCK:
      begin
        next_s.lock = `PVM_LOCK_RST;
        next_s.st = PVM_ST_IDLE;
        next_s.ready = 1'b1;
      end
      default:
      begin
        next_s.st = PVM_ST_IDLE;
        next_s.ready = 1'b1;
      end
    endcase

    // read path; bus only driven while output enable is low in the mode
    next_s.doe = mode_active && !output_enable_n;
    next_s.dout = 8'h00;
    if (mode_active && !output_enable_n)
    begin
      if (s.command == `PVM_CMD_FLASH_RD)
        next_s.dout = byte_select_first ? flash_word[15:8] : flash_word[7:0];
      else if (s.command == `PVM_CMD_EE_RD && !byte_select_first)
        next_s.dout = ee_byte;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s <= '0;
      s.st <= PVM_ST_IDLE;
      s.op <= PVM_OP_ERASE;
      s.command <= `PVM_CMD_NOP;
      s.ready <= 1'b1;
      s.prev_write_n <= 1'b1;
      s.fuse_low <= FUSE_LOW_INIT;
      s.fuse_high <= FUSE_HIGH_INIT;
      s.lock <= `PVM_LOCK_RST;
      s.fbuf <= '1;
      s.ebuf <= '1;
      s.flash <= '1;
      s.eeprom <= '1;
    end
    else
      s <= next_s;
  end

  // all of these are fields of the registered state
  assign data_out = s.dout;
  assign data_oe = s.doe;
  assign programming_done_flag = s.ready;
  assign fuse_low = s.fuse_low;
  assign fuse_high = s.fuse_high;
  assign lock_bits = s.lock;
  assign engine_state = s.st;

endmodule : pvm_port

// [bench/pvm_port_chk.sv]
`timescale 1ns/1ns
module pvm_port_chk #(
  parameter int PROG_CYC = 4,
  parameter int ERASE_CYC = 6
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic high_voltage,
  input wire logic write_n,
  input wire logic output_enable_n,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  input wire logic programming_done_flag,
  input wire logic [7:0] fuse_low,
  input wire logic [7:0] fuse_high
);
  // counter so busy length follows the parameters
  int busy_cnt;
  always_ff @(posedge clk)
  begin
    if (rst || programming_done_flag)
      busy_cnt <= 0;
    else
      busy_cnt <= busy_cnt + 1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_busy_cause: assert property ($fell(programming_done_flag) |->
    !$past(write_n) && $past(write_n, 2)) else $error("busy without write fall");
  a_busy_length: assert property ($rose(programming_done_flag) |->
    busy_cnt == PROG_CYC + 1 || busy_cnt == ERASE_CYC + 2) else $error("busy length");
  a_busy_bounded: assert property (!programming_done_flag |->
    busy_cnt < ERASE_CYC + 2) else $error("busy too long");
  a_fuse_at_done: assert property ($changed(fuse_low) || $changed(fuse_high) |->
    $rose(programming_done_flag)) else $error("fuse changed outside done");
  a_oe_follows: assert property (data_oe |-> !$past(output_enable_n))
    else $error("bus driven without enable");
  a_oe_release: assert property (output_enable_n |=> !data_oe)
    else $error("bus not released");
  a_idle_zero: assert property (!data_oe |-> data_out == 8'h00)
    else $error("data not zero when idle");
  a_off_ready: assert property (!high_voltage |-> programming_done_flag)
    else $error("busy outside mode");
  a_off_quiet: assert property (!high_voltage |=> !data_oe)
    else $error("bus driven outside mode");
endmodule : pvm_port_chk

bind pvm_port pvm_port_chk #(.PROG_CYC(PROG_CYC), .ERASE_CYC(ERASE_CYC)) u_chk
(
  .clk, .rst, .high_voltage, .write_n, .output_enable_n, .data_out, .data_oe,
  .programming_done_flag, .fuse_low, .fuse_high
);

// [bench/pvm_prog_model.sv]
`timescale 1ns/1ns
module pvm_prog_model
(
  input wire logic clk,
  input wire logic programming_done_flag,
  input wire logic data_oe,
  input wire logic [7:0] bus,
  output logic high_voltage,
  output logic load_strobe,
  output logic strobe_action_msb,
  output logic strobe_action_lsb,
  output logic byte_select_first,
  output logic byte_select_second,
  output logic page_latch_pulse,
  output logic write_n,
  output logic output_enable_n,
  output logic [7:0] drive
);
  initial
  begin
    {high_voltage, load_strobe, strobe_action_msb, strobe_action_lsb} = 4'h0;
    {byte_select_first, byte_select_second, page_latch_pulse} = 3'h0;
    {write_n, output_enable_n} = 2'h3;
    drive = 8'h00;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic enter(input logic bad);
    high_voltage = 1'b0;
    {page_latch_pulse, strobe_action_msb, strobe_action_lsb, byte_select_first} = 4'h0;
    repeat (6)
    begin
      load_strobe = 1'b1;
      tick(1);
      load_strobe = 1'b0;
      tick(1);
    end
    tick(3);
    high_voltage = 1'b1;
    tick(1);
    byte_select_first = bad;
    tick(1);
    byte_select_first = 1'b0;
    tick(6);
  endtask : enter
  task automatic load(input logic [1:0] act, input logic bs1, input logic [7:0] val);
    {strobe_action_msb, strobe_action_lsb} = act;
    byte_select_first = bs1;
    drive = val;
    tick(1);
    load_strobe = 1'b1;
    tick(1);
    load_strobe = 1'b0;
    // released bus must not keep the old byte; changed here so a following
    // call never assigns the bus twice in one time step
    drive = ~val;
    tick(1);
  endtask : load
  task automatic latch();
    byte_select_first = 1'b1;
    tick(1);
    page_latch_pulse = 1'b1;
    tick(1);
    page_latch_pulse = 1'b0;
    tick(1);
  endtask : latch
  task automatic write(input logic bs1, input logic bs2);
    byte_select_first = bs1;
    byte_select_second = bs2;
    tick(1);
    write_n = 1'b0;
    tick(2);
    write_n = 1'b1;
    byte_select_second = 1'b0;
  endtask : write
  task automatic wait_ready(output logic ok);
    int n;
    n = 0;
    while (programming_done_flag !== 1'b1 && n < 50)
    begin
      tick(1);
      n++;
    end
    ok = programming_done_flag;
  endtask : wait_ready
  task automatic read(input logic bs1, output logic [8:0] val);
    byte_select_first = bs1;
    output_enable_n = 1'b0;
    tick(2);
    val = {data_oe, bus};
    output_enable_n = 1'b1;
    tick(1);
  endtask : read
endmodule : pvm_prog_model

// [bench/tb_pvm_port.sv]
`timescale 1ns/1ns
`include "pvm_regs.svh"
module tb_pvm_port;
  import pvm_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic high_voltage, load_strobe, strobe_action_msb, strobe_action_lsb;
  logic byte_select_first, byte_select_second, page_latch_pulse, write_n;
  logic output_enable_n, data_oe, programming_done_flag;
  logic [7:0] drive, bus, data_out, fuse_low, fuse_high, lock_bits;
  pvm_state_t engine_state;
  int miscompares = 0;
  int check_count = 0;
  assign bus = data_oe ? data_out : drive;
  always #20 clk = ~clk;
  pvm_port #(.FLASH_AW(9), .PROG_CYC(4), .ERASE_CYC(6)) dut
  (
    .clk, .rst, .high_voltage, .load_strobe, .strobe_action_msb, .strobe_action_lsb,
    .byte_select_first, .byte_select_second, .page_latch_pulse, .write_n,
    .output_enable_n, .data_in(bus), .data_out, .data_oe, .programming_done_flag,
    .fuse_low, .fuse_high, .lock_bits, .engine_state
  );
  pvm_prog_model prog
  (
    .clk, .programming_done_flag, .data_oe, .bus, .high_voltage, .load_strobe,
    .strobe_action_msb, .strobe_action_lsb, .byte_select_first, .byte_select_second,
    .page_latch_pulse, .write_n, .output_enable_n, .drive
  );
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  task automatic cmd(input logic [7:0] c);
    prog.load(PVM_ACT_CMD, 1'b0, c);
  endtask : cmd
  task automatic adr(input logic bs1, input logic [7:0] a);
    prog.load(PVM_ACT_ADDR, bs1, a);
  endtask : adr
  task automatic rd(input logic bs1, input logic [7:0] exp);
    logic [8:0] v;
    prog.read(bs1, v);
    check(v, {1'b1, exp});
  endtask : rd
  task automatic burn(input logic bs1, input logic bs2);
    logic ok;
    prog.write(bs1, bs2);
    check({8'h00, programming_done_flag}, 9'h000);
    check({7'h00, engine_state}, {7'h00, PVM_ST_BUSY});
    prog.wait_ready(ok);
    check({8'h00, ok}, 9'h001);
    check({7'h00, engine_state}, {7'h00, PVM_ST_IDLE});
  endtask : burn
  initial
  begin
    logic [8:0] v;
    logic ok;
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    check({1'b0, fuse_low}, {1'b0, `PVM_FUSE_LOW_RST});
    check({1'b0, fuse_high}, {1'b0, `PVM_FUSE_HIGH_RST});
    check({1'b0, lock_bits}, {1'b0, `PVM_LOCK_RST});
    prog.enter(1'b1);
    cmd(`PVM_CMD_ERASE);
    prog.write(1'b0, 1'b0);
    check({8'h00, programming_done_flag}, 9'h001);
    prog.read(1'b0, v);
    check({8'h00, v[8]}, 9'h000);
    prog.enter(1'b0);
    // memories start erased, so no erase is owed before the first write
    cmd(`PVM_CMD_FLASH_WR);
    adr(1'b1, 8'h01);
    for (int i = 0; i < 2; i++)
    begin
      adr(1'b0, 8'h85 + 8'(i));
      prog.load(PVM_ACT_DATA, 1'b0, 8'h34 + 8'(i));
      prog.load(PVM_ACT_DATA, 1'b1, 8'h12 + 8'(i));
      prog.latch();
    end
    prog.write(1'b0, 1'b0);
    adr(1'b0, 8'h00);
    prog.wait_ready(ok);
    check({8'h00, ok}, 9'h001);
    cmd(`PVM_CMD_FLASH_RD);
    rd(1'b0, 8'h35);
    rd(1'b1, 8'h13);
    // word never latched keeps the erased value, so 0xFF needs no write
    adr(1'b0, 8'h87);
    rd(1'b0, 8'hFF);
    adr(1'b0, 8'h85);
    prog.load(PVM_ACT_IDLE, 1'b0, 8'h05);
    rd(1'b0, 8'h34);
    rd(1'b1, 8'h12);
    adr(1'b0, 8'h05);
    rd(1'b0, 8'hFF);
    adr(1'b1, 8'h00);
    adr(1'b0, 8'h85);
    rd(1'b1, 8'hFF);
    cmd(`PVM_CMD_EE_WR);
    adr(1'b0, 8'h0A);
    prog.load(PVM_ACT_DATA, 1'b0, 8'h5A);
    prog.latch();
    burn(1'b0, 1'b0);
    cmd(`PVM_CMD_EE_RD);
    rd(1'b0, 8'h5A);
    cmd(`PVM_CMD_FUSE_WR);
    prog.load(PVM_ACT_DATA, 1'b0, 8'hA5);
    burn(1'b0, 1'b0);
    check({1'b0, fuse_low}, 9'h0A5);
    prog.load(PVM_ACT_DATA, 1'b0, 8'hF7);
    burn(1'b1, 1'b0);
    check({1'b0, fuse_high}, 9'h0F7);
    cmd(`PVM_CMD_NOP);
    prog.write(1'b0, 1'b0);
    check({8'h00, programming_done_flag}, 9'h001);
    for (int k = 0; k < 2; k++)
    begin
      cmd(`PVM_CMD_ERASE);
      burn(1'b0, 1'b0);
      check({1'b0, lock_bits}, {1'b0, `PVM_LOCK_RST});
      check({1'b0, fuse_low}, 9'h0A5);
      cmd(`PVM_CMD_FLASH_RD);
      adr(1'b1, 8'h01);
      adr(1'b0, 8'h85);
      rd(1'b0, 8'hFF);
      cmd(`PVM_CMD_EE_RD);
      adr(1'b1, 8'h00);
      adr(1'b0, 8'h0A);
      rd(1'b0, k == 0 ? 8'h5A : 8'hFF);
      cmd(`PVM_CMD_FUSE_WR);
      prog.load(PVM_ACT_DATA, 1'b0, 8'hFF);
      burn(1'b1, 1'b0);
    end
    // fallback path: clock source fuses to 0000, leave the mode, enter again
    cmd(`PVM_CMD_FUSE_WR);
    prog.load(PVM_ACT_DATA, 1'b0, 8'hA0);
    burn(1'b0, 1'b0);
    check({1'b0, fuse_low}, 9'h0A0);
    prog.enter(1'b0);
    cmd(`PVM_CMD_EE_RD);
    rd(1'b0, 8'hFF);
    report_and_stop();
  end
  initial
  begin
    #200000;
    miscompares++;
    report_and_stop();
  end
endmodule : tb_pvm_port
